// file: inc/pifb_pkg.sv
/*
  Constants for the peripheral interrupt flag bank: register offsets, flag
  bit positions, implemented-bit masks, reset values and the capture/compare
  mode encoding.
  Assumes an 8-bit register port with byte offsets.
*/
`default_nettype none

package pifb_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFF_FLAGS_CLK_LOGIC = 8'h00;
  localparam logic [7:0] OFF_FLAGS_WAVE_CAP  = 8'h04;
  localparam logic [7:0] OFF_MASK_CLK_LOGIC  = 8'h08;
  localparam logic [7:0] OFF_MASK_WAVE_CAP   = 8'h0C;
  localparam logic [7:0] OFF_PEND_CLK_LOGIC  = 8'h10;
  localparam logic [7:0] OFF_PEND_WAVE_CAP   = 8'h14;
  localparam logic [7:0] OFF_CELL_EDGE_CFG   = 8'h18;

  // First flag register bit positions
  localparam int unsigned BIT_OSC_FAIL    = 7;
  localparam int unsigned BIT_CLK_SWITCH  = 6;
  localparam int unsigned BIT_CELL_B      = 1;
  localparam int unsigned BIT_CELL_A      = 0;

  // Second flag register bit positions
  localparam int unsigned BIT_WAVE_SHUT   = 6;
  localparam int unsigned BIT_CAPCOMP_B   = 1;
  localparam int unsigned BIT_CAPCOMP_A   = 0;

  // Implemented bits; all others read zero and ignore writes
  localparam logic [7:0] IMPL_CLK_LOGIC = 8'hC3;
  localparam logic [7:0] IMPL_WAVE_CAP  = 8'h43;

  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_MASK  = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Edge configuration: bit layout and reset (rising edges only)
  localparam int unsigned CFG_A_RISE = 0;
  localparam int unsigned CFG_A_FALL = 1;
  localparam int unsigned CFG_B_RISE = 2;
  localparam int unsigned CFG_B_FALL = 3;
  localparam logic [3:0]  RST_EDGE_CFG = 4'h5;

  // Level event vector positions for the edge detector
  localparam int unsigned LVL_CELL_A   = 0;
  localparam int unsigned LVL_CELL_B   = 1;
  localparam int unsigned LVL_OSC_FAIL = 2;
  localparam int unsigned LVL_SHUTDOWN = 3;
  localparam int unsigned LVL_COUNT    = 4;

  typedef enum logic [1:0] {
    PIFB_CC_OFF     = 2'h0,
    PIFB_CC_CAPTURE = 2'h1,
    PIFB_CC_COMPARE = 2'h3,
    PIFB_CC_PWM     = 2'h2
  } pifb_ccmode_t;

endpackage : pifb_pkg

`default_nettype wire

// file: logic/pifb_edge_detect.sv
/*
  Edge detector for level event sources: a registered one-cycle pulse on
  each enabled rising or falling edge.
  Assumes its levels come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pifb_edge_detect #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] level,
  input  wire logic [WIDTH-1:0] rise_en,
  input  wire logic [WIDTH-1:0] fall_en,
  output logic      [WIDTH-1:0] pulse
);
  import pifb_pkg::*;

  logic [WIDTH-1:0] level_prev;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      level_prev <= '0;
    end else begin
      level_prev <= level;
    end
  end

  // A level already high at reset release counts as a rising edge
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pulse <= '0;
    end else begin
      pulse <= (rise_en & level & ~level_prev)
             | (fall_en & ~level & level_prev);
    end
  end

endmodule // pifb_edge_detect

`default_nettype wire

// file: logic/pifb_flag_reg.sv
/*
  Sticky flag register: hardware sets, software writes either the value
  directly or clears with ones. Only implemented bits hold state.
  Assumes set pulses and the write strobe are on mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module pifb_flag_reg #(
  parameter int unsigned WIDTH     = 8,
  parameter logic [WIDTH-1:0] IMPL = '1,
  parameter bit          W1C       = 1'b0
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic             wr,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] flags
);
  import pifb_pkg::*;

  logic [WIDTH-1:0] next_flags;

  always_comb begin
    next_flags = flags;
    if (wr) begin
      next_flags = W1C ? (flags & ~wdata) : wdata;
    end
    // Set beats a simultaneous clear so no event is lost
    next_flags = (next_flags | set) & IMPL;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

endmodule // pifb_flag_reg

`default_nettype wire

// file: logic/pifb_flags_bank.sv
/*
  Peripheral interrupt flag bank: two 8-bit hardware-set flag registers
  for clock, logic-cell, waveform-generator and capture/compare events,
  with mask, write-one-to-clear pending copies and one interrupt line.
  Assumes all event sources are on-chip logic clocked by mclk and a
  register master that never needs wait states.
*/
// The address-and-strobe port and the register offsets were left to the implementer.

`timescale 1ns/1ps
`default_nettype none

module pifb_flags_bank (
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  // Register port
  input  wire logic [pifb_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [pifb_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [pifb_pkg::DATA_W-1:0] reg_rdata,
  // Clock system events
  input  wire logic                        osc_fail_detect,
  input  wire logic                        clock_switch_done,
  // Logic cell outputs
  input  wire logic                        logic_cell_a_output,
  input  wire logic                        logic_cell_b_output,
  // Waveform generator
  input  wire logic                        waveform_shutdown,
  // Capture/compare unit A
  input  wire logic [1:0]                  capcomp_a_mode_select,
  input  wire logic                        capcomp_a_capture,
  input  wire logic                        capcomp_a_match,
  input  wire logic                        capcomp_a_trail,
  // Capture/compare unit B
  input  wire logic [1:0]                  capcomp_b_mode_select,
  input  wire logic                        capcomp_b_capture,
  input  wire logic                        capcomp_b_match,
  input  wire logic                        capcomp_b_trail,
  // Flag views and interrupt
  output logic      [pifb_pkg::DATA_W-1:0] irq_flags_clock_and_logic,
  output logic      [pifb_pkg::DATA_W-1:0] irq_flags_waveform_and_capture,
  output logic                             irq
);
  import pifb_pkg::*;

  // Selects the one event that counts in the unit's current mode
  function automatic logic capcomp_event(
    input logic [1:0] mode,
    input logic       capture,
    input logic       match,
    input logic       trail
  );
    logic hit;
    hit = 1'b0;
    case (pifb_ccmode_t'(mode))
      PIFB_CC_CAPTURE: hit = capture;
      PIFB_CC_COMPARE: hit = match;
      PIFB_CC_PWM:     hit = trail;
      PIFB_CC_OFF:     hit = 1'b0;
      default:         hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic addr_is(
    input logic [ADDR_W-1:0] addr,
    input logic [7:0]        offset
  );
    return addr == offset;
  endfunction

  // Shared by both register pairs feeding the interrupt line
  function automatic logic any_unmasked(
    input logic [DATA_W-1:0] pend,
    input logic [DATA_W-1:0] mask
  );
    return |(pend & mask);
  endfunction

  // Edge config width follows its reset constant
  localparam int unsigned CFG_W = $bits(RST_EDGE_CFG);

  logic [DATA_W-1:0]    mask_clk_logic;
  logic [DATA_W-1:0]    mask_wave_cap;
  logic [DATA_W-1:0]    pend_clk_logic;
  logic [DATA_W-1:0]    pend_wave_cap;
  logic [CFG_W-1:0]     cell_edge_cfg;
  logic [LVL_COUNT-1:0] lvl_vec;
  logic [LVL_COUNT-1:0] lvl_rise_en;
  logic [LVL_COUNT-1:0] lvl_fall_en;
  logic [LVL_COUNT-1:0] lvl_pulse;
  logic [DATA_W-1:0]    set_clk_logic;
  logic [DATA_W-1:0]    set_wave_cap;
  logic                 wr_flags_clk_logic;
  logic                 wr_flags_wave_cap;
  logic                 wr_pend_clk_logic;
  logic                 wr_pend_wave_cap;
  logic [DATA_W-1:0]    next_rdata;
  logic                 wr_mask_clk_logic;
  logic                 wr_mask_wave_cap;
  logic                 wr_edge_cfg;

  // Level sources go through the edge detector
  always_comb begin
    lvl_vec                = '0;
    lvl_vec[LVL_CELL_A]    = logic_cell_a_output;
    lvl_vec[LVL_CELL_B]    = logic_cell_b_output;
    lvl_vec[LVL_OSC_FAIL]  = osc_fail_detect;
    lvl_vec[LVL_SHUTDOWN]  = waveform_shutdown;
  end

  // Oscillator and shutdown fire on entry only; cells are configurable
  always_comb begin
    lvl_rise_en               = '0;
    lvl_fall_en               = '0;
    lvl_rise_en[LVL_CELL_A]   = cell_edge_cfg[CFG_A_RISE];
    lvl_fall_en[LVL_CELL_A]   = cell_edge_cfg[CFG_A_FALL];
    lvl_rise_en[LVL_CELL_B]   = cell_edge_cfg[CFG_B_RISE];
    lvl_fall_en[LVL_CELL_B]   = cell_edge_cfg[CFG_B_FALL];
    lvl_rise_en[LVL_OSC_FAIL] = 1'b1;
    lvl_rise_en[LVL_SHUTDOWN] = 1'b1;
  end

  pifb_edge_detect #(
    .WIDTH   (LVL_COUNT)
  ) u_edges (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .level   (lvl_vec),
    .rise_en (lvl_rise_en),
    .fall_en (lvl_fall_en),
    .pulse   (lvl_pulse)
  );

  // Set vectors; masks play no part in setting, the edge enables gate the cell flags
  always_comb begin
    set_clk_logic = ZERO_BYTE;
    set_wave_cap  = ZERO_BYTE;
    set_clk_logic[BIT_OSC_FAIL] = lvl_pulse[LVL_OSC_FAIL];
    set_clk_logic[BIT_CLK_SWITCH] = clock_switch_done;
    set_clk_logic[BIT_CELL_B] = lvl_pulse[LVL_CELL_B];
    set_clk_logic[BIT_CELL_A] = lvl_pulse[LVL_CELL_A];
    set_wave_cap[BIT_WAVE_SHUT] = lvl_pulse[LVL_SHUTDOWN];
    set_wave_cap[BIT_CAPCOMP_B] = capcomp_event(capcomp_b_mode_select,
                                                capcomp_b_capture,
                                                capcomp_b_match,
                                                capcomp_b_trail);
    set_wave_cap[BIT_CAPCOMP_A] = capcomp_event(capcomp_a_mode_select,
                                                capcomp_a_capture,
                                                capcomp_a_match,
                                                capcomp_a_trail);
  end

  // Write decode
  always_comb begin
    wr_flags_clk_logic = reg_wr && addr_is(reg_addr, OFF_FLAGS_CLK_LOGIC);
    wr_flags_wave_cap  = reg_wr && addr_is(reg_addr, OFF_FLAGS_WAVE_CAP);
    wr_pend_clk_logic  = reg_wr && addr_is(reg_addr, OFF_PEND_CLK_LOGIC);
    wr_pend_wave_cap   = reg_wr && addr_is(reg_addr, OFF_PEND_WAVE_CAP);
    wr_mask_clk_logic  = reg_wr && addr_is(reg_addr, OFF_MASK_CLK_LOGIC);
    wr_mask_wave_cap   = reg_wr && addr_is(reg_addr, OFF_MASK_WAVE_CAP);
    wr_edge_cfg        = reg_wr && addr_is(reg_addr, OFF_CELL_EDGE_CFG);
  end

  // Directly writable flags, zero at reset
  pifb_flag_reg #(
    .WIDTH (DATA_W),
    .IMPL  (IMPL_CLK_LOGIC),
    .W1C   (1'b0)
  ) u_flags_clk_logic (
    .mclk  (mclk),
    .rst_b (rst_b),
    .set   (set_clk_logic),
    .wr    (wr_flags_clk_logic),
    .wdata (reg_wdata),
    .flags (irq_flags_clock_and_logic)
  );

  pifb_flag_reg #(
    .WIDTH (DATA_W),
    .IMPL  (IMPL_WAVE_CAP),
    .W1C   (1'b0)
  ) u_flags_wave_cap (
    .mclk  (mclk),
    .rst_b (rst_b),
    .set   (set_wave_cap),
    .wr    (wr_flags_wave_cap),
    .wdata (reg_wdata),
    .flags (irq_flags_waveform_and_capture)
  );

  // Pending copies clear by writing ones, leaving the flags untouched
  pifb_flag_reg #(
    .WIDTH (DATA_W),
    .IMPL  (IMPL_CLK_LOGIC),
    .W1C   (1'b1)
  ) u_pend_clk_logic (
    .mclk  (mclk),
    .rst_b (rst_b),
    .set   (set_clk_logic),
    .wr    (wr_pend_clk_logic),
    .wdata (reg_wdata),
    .flags (pend_clk_logic)
  );

  pifb_flag_reg #(
    .WIDTH (DATA_W),
    .IMPL  (IMPL_WAVE_CAP),
    .W1C   (1'b1)
  ) u_pend_wave_cap (
    .mclk  (mclk),
    .rst_b (rst_b),
    .set   (set_wave_cap),
    .wr    (wr_pend_wave_cap),
    .wdata (reg_wdata),
    .flags (pend_wave_cap)
  );

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mask_clk_logic <= RST_MASK;
    end else if (wr_mask_clk_logic) begin
      mask_clk_logic <= reg_wdata & IMPL_CLK_LOGIC;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mask_wave_cap <= RST_MASK;
    end else if (wr_mask_wave_cap) begin
      mask_wave_cap <= reg_wdata & IMPL_WAVE_CAP;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cell_edge_cfg <= RST_EDGE_CFG;
    end else if (wr_edge_cfg) begin
      cell_edge_cfg <= reg_wdata[CFG_W-1:0];
    end
  end

  // Interrupt follows pending, so clearing pending drops the line
  // Registered: the line trails pending by one cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= any_unmasked(pend_clk_logic, mask_clk_logic)
           | any_unmasked(pend_wave_cap, mask_wave_cap);
    end
  end

  // Unused bits and unmapped offsets read zero
  always_comb begin
    next_rdata = ZERO_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        OFF_FLAGS_CLK_LOGIC: next_rdata = irq_flags_clock_and_logic;
        OFF_FLAGS_WAVE_CAP:  next_rdata = irq_flags_waveform_and_capture;
        OFF_MASK_CLK_LOGIC:  next_rdata = mask_clk_logic;
        OFF_MASK_WAVE_CAP:   next_rdata = mask_wave_cap;
        OFF_PEND_CLK_LOGIC:  next_rdata = pend_clk_logic;
        OFF_PEND_WAVE_CAP:   next_rdata = pend_wave_cap;
        OFF_CELL_EDGE_CFG:   next_rdata = DATA_W'(cell_edge_cfg);
        default:             next_rdata = ZERO_BYTE;
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      reg_rdata <= ZERO_BYTE;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // pifb_flags_bank

`default_nettype wire

// file: test/pifb_flags_bank_assertions.sv
/* Checker on the flag bank ports, bound to every instance.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module pifb_flags_bank_chk
  import pifb_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              osc_fail_detect,
  input wire logic              clock_switch_done,
  input wire logic              waveform_shutdown,
  input wire logic [1:0]        capcomp_a_mode_select,
  input wire logic              capcomp_a_capture,
  input wire logic              capcomp_a_trail,
  input wire logic [1:0]        capcomp_b_mode_select,
  input wire logic              capcomp_b_match,
  input wire logic [DATA_W-1:0] irq_flags_clock_and_logic,
  input wire logic [DATA_W-1:0] irq_flags_waveform_and_capture
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // Level sources pass an edge detector first
  sequence rose_seen(x);
    $rose(x) ##1 1'b1;
  endsequence
  unused_zero_a: assert property (
    ((irq_flags_clock_and_logic & ~IMPL_CLK_LOGIC) == 8'h00) &&
    ((irq_flags_waveform_and_capture & ~IMPL_WAVE_CAP) == 8'h00))
    else $error("unused flag bit set");
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  read_back_a: assert property (
    reg_rd && reg_addr == OFF_FLAGS_CLK_LOGIC
    |=> reg_rdata == $past(irq_flags_clock_and_logic))
    else $error("flag read wrong");
  osc_fail_set_a: assert property (
    rose_seen(osc_fail_detect) |=> irq_flags_clock_and_logic[7])
    else $error("osc failure flag not set");
  switch_done_a: assert property (
    clock_switch_done |=> irq_flags_clock_and_logic[6])
    else $error("switch flag not set");
  shutdown_set_a: assert property (
    rose_seen(waveform_shutdown) |=> irq_flags_waveform_and_capture[6])
    else $error("shutdown flag not set");
  capture_set_a: assert property (
    capcomp_a_capture && capcomp_a_mode_select == PIFB_CC_CAPTURE
    |=> irq_flags_waveform_and_capture[0])
    else $error("capture flag not set");
  compare_set_a: assert property (
    capcomp_b_match && capcomp_b_mode_select == PIFB_CC_COMPARE
    |=> irq_flags_waveform_and_capture[1])
    else $error("compare flag not set");
  flags_sticky_a: assert property (
    !reg_wr |=> (irq_flags_clock_and_logic &
    $past(irq_flags_clock_and_logic)) == $past(irq_flags_clock_and_logic))
    else $error("flag cleared without write");
  mode_gate_a: assert property (
    capcomp_a_capture && !capcomp_a_trail && !reg_wr &&
    capcomp_a_mode_select == PIFB_CC_PWM &&
    !irq_flags_waveform_and_capture[0]
    |=> !irq_flags_waveform_and_capture[0])
    else $error("event of wrong mode set flag");
endmodule // pifb_flags_bank_chk
bind pifb_flags_bank pifb_flags_bank_chk i_chk (
  .mclk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
  .osc_fail_detect, .clock_switch_done, .waveform_shutdown,
  .capcomp_a_mode_select, .capcomp_a_capture, .capcomp_a_trail,
  .capcomp_b_mode_select, .capcomp_b_match,
  .irq_flags_clock_and_logic, .irq_flags_waveform_and_capture);
`default_nettype wire

// file: test/pifb_event_src.sv
/* Model of the peripherals raising events: held levels and one-cycle
   pulses of the chosen capture/compare kind.
   Assumes one-cycle request bits on mclk. */
`timescale 1ns/1ps
`default_nettype none
module pifb_event_src (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [6:0] ev,
  input  wire logic [1:0] kind,
  output logic      [3:0] lvl,
  output logic            sw,
  output logic      [2:0] cca,
  output logic      [2:0] ccb
);
  logic [3:0] hold [4];
  logic [2:0] pick;
  // One kind only, so the mode gate is exercised
  assign pick = (kind == 2'h1) ? 3'h1 : ((kind == 2'h3) ? 3'h2 : 3'h4);
  always_ff @(posedge mclk) begin
    sw <= rst_b & ev[4];
    cca <= (rst_b & ev[5]) ? pick : 3'h0;
    ccb <= (rst_b & ev[6]) ? pick : 3'h0;
  end
  // Long levels show that a held level sets once
  always_ff @(posedge mclk) begin
    for (int j = 0; j < 4; j++) begin
      if (!rst_b) begin
        lvl[j] <= 1'b0;
        hold[j] <= 4'h0;
      end else if (ev[j]) begin
        lvl[j] <= 1'b1;
        hold[j] <= 4'hC;
      end else if (hold[j] != 4'h0) begin
        hold[j] <= hold[j] - 4'h1;
      end else begin
        lvl[j] <= 1'b0;
      end
    end
  end
endmodule // pifb_event_src
`default_nettype wire

// file: test/peripheral_irq_flags_bank_tb.sv
/* Self-checking bench: register tasks, event model, each event source
   in turn with random masks and modes, fixed corner rounds, mask and clear of the interrupt.
   Assumes the package, design and models are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_flags_bank_tb;
  import pifb_pkg::*;
  logic        mclk, rst_b, reg_wr, reg_rd, irq, sw;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, fc, fw, m;
  logic [1:0]  ma, mb, kind, k, a, b;
  logic [1:0]  kt [3] = '{2'h1, 2'h3, 2'h2};
  logic [6:0]  ev;
  logic [3:0]  lvl;
  logic [2:0]  cca, ccb;
  logic [31:0] r;
  logic [15:0] e;
  int          err_count, n_checks, cyc;
  pifb_flags_bank i_dut (
    .mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .osc_fail_detect(lvl[2]), .clock_switch_done(sw),
    .logic_cell_a_output(lvl[0]), .logic_cell_b_output(lvl[1]),
    .waveform_shutdown(lvl[3]), .capcomp_a_mode_select(ma),
    .capcomp_a_capture(cca[0]), .capcomp_a_match(cca[1]),
    .capcomp_a_trail(cca[2]), .capcomp_b_mode_select(mb),
    .capcomp_b_capture(ccb[0]), .capcomp_b_match(ccb[1]),
    .capcomp_b_trail(ccb[2]), .irq_flags_clock_and_logic(fc),
    .irq_flags_waveform_and_capture(fw), .irq);
  pifb_event_src i_src (.mclk, .rst_b, .ev, .kind, .lvl, .sw, .cca, .ccb);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    r = r ^ (r << 13);
    r = r ^ (r >> 17);
    r = r ^ (r << 5);
    return r;
  endfunction
  function automatic logic [15:0] expv(int i, logic [1:0] k, a, b);
    case (i)
      0: return 16'h0001;
      1: return 16'h0002;
      2: return 16'h0080;
      3: return 16'h4000;
      4: return 16'h0040;
      5: return (k == a) ? 16'h0100 : 16'h0000;
      default: return (k == b) ? 16'h0200 : 16'h0000;
    endcase
  endfunction
  task automatic chk(input string n, input logic [7:0] s, x);
    n_checks++;
    if (s !== x) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [7:0] ad, v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, x, input string n);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(n, reg_rdata, x);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, ma, mb, kind, ev} = '0;
    rst_b = 1'b0;
    r = 32'h0000005E;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    rd(OFF_FLAGS_CLK_LOGIC, 8'h00, "flags_cl");
    rd(OFF_FLAGS_WAVE_CAP, 8'h00, "flags_wc");
    rd(OFF_CELL_EDGE_CFG, 8'h05, "edge_cfg");
    wr(OFF_FLAGS_CLK_LOGIC, 8'hFF);
    wr(OFF_FLAGS_WAVE_CAP, 8'hFF);
    wr(8'h1C, 8'hFF);
    rd(8'h1C, 8'h00, "unmapped");
    rd(OFF_FLAGS_CLK_LOGIC, 8'hC3, "set_cl");
    rd(OFF_FLAGS_WAVE_CAP, 8'h43, "set_wc");
    for (int i = 0; i < 56; i++) begin
      r = rnd();
      k = kt[(i / 7) % 3];
      a = (i < 21) ? k : ((i < 28) ? {k[0], k[1]} : r[1:0]);
      b = (i < 28) ? k : r[3:2];
      m = r[8] ? 8'hFF : 8'h00;
      e = expv(i % 7, k, a, b);
      ma <= a;
      mb <= b;
      kind <= k;
      wr(OFF_FLAGS_CLK_LOGIC, 8'h00);
      wr(OFF_FLAGS_WAVE_CAP, 8'h00);
      wr(OFF_PEND_CLK_LOGIC, 8'hFF);
      wr(OFF_PEND_WAVE_CAP, 8'hFF);
      wr(OFF_MASK_CLK_LOGIC, m);
      wr(OFF_MASK_WAVE_CAP, m);
      ev[i % 7] <= 1'b1;
      @(posedge mclk);
      ev <= 7'h00;
      repeat (4) @(posedge mclk);
      rd(OFF_FLAGS_CLK_LOGIC, e[7:0], "ev_cl");
      rd(OFF_FLAGS_WAVE_CAP, e[15:8], "ev_wc");
      rd(OFF_PEND_CLK_LOGIC, e[7:0], "pend_cl");
      rd(OFF_PEND_WAVE_CAP, e[15:8], "pend_wc");
      rd(OFF_MASK_CLK_LOGIC, m & IMPL_CLK_LOGIC, "mask_cl");
      rd(OFF_MASK_WAVE_CAP, m & IMPL_WAVE_CAP, "mask_wc");
      chk("irq", {7'h0, irq}, {7'h0, (|e) & m[0]});
      wr(OFF_FLAGS_CLK_LOGIC, 8'h00);
      wr(OFF_FLAGS_WAVE_CAP, 8'h00);
      rd(OFF_FLAGS_CLK_LOGIC, 8'h00, "clr_cl");
      rd(OFF_FLAGS_WAVE_CAP, 8'h00, "clr_wc");
      wr(OFF_PEND_CLK_LOGIC, 8'hFF);
      wr(OFF_PEND_WAVE_CAP, 8'hFF);
      repeat (2) @(posedge mclk);
      #1 chk("irq_clr", {7'h0, irq}, 8'h00);
      repeat (8) @(posedge mclk);
    end
    // Falling edges only: the rise must not set, the fall must
    wr(OFF_CELL_EDGE_CFG, 8'h0A);
    wr(OFF_FLAGS_CLK_LOGIC, 8'h00);
    ev <= 7'h03;
    @(posedge mclk);
    ev <= 7'h00;
    repeat (4) @(posedge mclk);
    rd(OFF_FLAGS_CLK_LOGIC, 8'h00, "rise_masked");
    repeat (14) @(posedge mclk);
    rd(OFF_FLAGS_CLK_LOGIC, 8'h03, "fall_seen");
    wr(OFF_CELL_EDGE_CFG, 8'h05);
    wr(OFF_FLAGS_WAVE_CAP, 8'hFF);
    wr(OFF_FLAGS_CLK_LOGIC, 8'hFF);
    rst_b <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    rd(OFF_FLAGS_CLK_LOGIC, 8'h00, "rst_cl");
    rd(OFF_FLAGS_WAVE_CAP, 8'h00, "rst_wc");
    complete_run();
  end
endmodule // peripheral_irq_flags_bank_tb
`default_nettype wire
